// ---- scwp_bench.sv ----
// bench joining host and device ends, checking the decoded registers
`timescale 1ns/1ps
module scwp_bench;
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  logic        sendValid = 1'b0;
  logic [15:0] sendWord = 16'h0000;
  logic        sendLast = 1'b0;
  logic        freq_select_pin = 1'b0;
  logic        tieLow = 1'b0;
  logic        sendReady, busy, squareOutEnable, wordStrobe;
  logic        coreReset, dacSleep;
  logic [15:0] controlWord;
  logic [27:0] freq_reg_zero, freq_reg_one, phaseIncrement;
  logic [11:0] phaseReg0, phaseReg1, phaseOffset;
  int          n_mismatch = 0;
  int          checked = 0;
  int          nWords = 0;
  int          i;
  scwp_if link ();
  scwp_host scwp_host_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .link(link), .sendValid(sendValid), .sendWord(sendWord),
    .sendLast(sendLast), .sendReady(sendReady), .busy(busy));
  // unused pins held low: their paths are outside these scenarios
  scwp_device scwp_device_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .link(link), .freq_select_pin(freq_select_pin),
    .phase_select_pin(tieLow), .resetPin(tieLow), .sleepPin(tieLow),
    .selLate(tieLow), .loadLate(tieLow), .controlWord(controlWord),
    .freq_reg_zero(freq_reg_zero), .freq_reg_one(freq_reg_one),
    .phaseReg0(phaseReg0), .phaseReg1(phaseReg1),
    .phaseIncrement(phaseIncrement), .phaseOffset(phaseOffset),
    .coreReset(coreReset), .dacSleep(dacSleep),
    .squareOutEnable(squareOutEnable), .wordStrobe(wordStrobe));
  scwp_sva scwp_sva_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .serialClk(link.serialClk), .frameSyncN(link.frameSyncN),
    .serialData(link.serialData));
  // 10 MHz core clock
  always #50 clk_sys = ~clk_sys;
  // count completed words seen by the device
  always @(posedge clk_sys) begin
    if (wordStrobe === 1'b1) nWords++;
  end
  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic cmp(input logic [27:0] got, input logic [27:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // request held until the edge that sees ready
  task automatic send(input logic [15:0] w, input logic last);
    int k;
    @(negedge clk_sys);
    sendValid = 1'b1;
    sendWord  = w;
    sendLast  = last;
    for (k = 0; k < 4000; k++) begin
      @(posedge clk_sys);
      if (sendReady === 1'b1) break;
    end
    if (k == 4000) begin
      n_mismatch++;
      $display("unexpected at %0t: send never accepted", $time);
    end
    @(negedge clk_sys);
    sendValid = 1'b0;
  endtask
  task automatic wait_words(input int n);
    int k;
    for (k = 0; k < 4000 && nWords < n; k++) @(negedge clk_sys);
    if (nWords < n) begin
      n_mismatch++;
      $display("unexpected at %0t: word never arrived", $time);
    end
    repeat (2) @(negedge clk_sys);
  endtask
  task automatic put(input logic [15:0] w);
    send(w, 1'b1);
    wait_words(nWords + 1);
  endtask
  initial begin
    repeat (10) @(negedge clk_sys);
    sys_rst = 1'b0;
    cmp({12'h000, controlWord}, {12'h000, scwp_pkg::CTRL_RESET_VALUE});
    put(16'h0030);
    cmp({12'h000, controlWord}, 28'h0000030);
    cmp({27'h0, squareOutEnable}, 28'h1);
    put(16'h0020);
    cmp({27'h0, squareOutEnable}, 28'h0);
    put(16'h4010);
    cmp({12'h000, controlWord}, 28'h0000020);
    cmp(freq_reg_zero, 28'h0000010);
    $display("test control done");
    i = nWords;
    send(16'h8ABC, 1'b0);
    send(16'h0200, 1'b1);
    wait_words(i + 2);
    cmp(freq_reg_one, 28'h0000ABC);
    cmp({12'h000, controlWord}, 28'h0000200);
    $display("test stream done");
    @(negedge clk_sys);
    freq_select_pin = 1'b1;
    for (i = 0; i < 40; i++) begin
      @(posedge clk_sys);
      if (phaseIncrement === 28'h0000ABC) break;
    end
    cmp(28'(i + 1), 28'(scwp_pkg::SEL_LATENCY));
    $display("test select done");
    put(16'h2000);
    put(16'h5234);
    cmp(freq_reg_zero, 28'h0000010);
    put(16'h4567);
    cmp(freq_reg_zero, 28'h159D234);
    $display("test full word done");
    close_out();
  end
  // watchdog well beyond the hundred-odd microseconds of traffic
  initial begin
    #2000000;
    n_mismatch++;
    close_out();
  end
endmodule

// ---- scwp_device.sv ----
// device end: serial receiver, word decode and core timing
`timescale 1ns/1ps
module scwp_device #(
  parameter int SEL_DELAY  = scwp_pkg::SEL_LATENCY,
  parameter int LOAD_DELAY = scwp_pkg::LOAD_LATENCY
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // serial link
  scwp_if.device           link,
  // pins from the board
  input  wire logic        freq_select_pin,
  input  wire logic        phase_select_pin,
  input  wire logic        resetPin,
  input  wire logic        sleepPin,
  input  wire logic        selLate,
  input  wire logic        loadLate,
  // core view
  output logic [15:0]      controlWord,
  output logic [27:0]      freq_reg_zero,
  output logic [27:0]      freq_reg_one,
  output logic [11:0]      phaseReg0,
  output logic [11:0]      phaseReg1,
  output logic [27:0]      phaseIncrement,
  output logic [11:0]      phaseOffset,
  output logic             coreReset,
  output logic             dacSleep,
  output logic             squareOutEnable,
  output logic             wordStrobe
);
  logic [1:0]  clkSync_q, fsSync_q, datSync_q;
  logic        clkPrev_q;
  logic [15:0] shift_q;
  logic [4:0]  count_q;
  logic [15:0] ctrl_q, ctrlCore_q;
  logic [27:0] f0_q, f1_q;
  logic [11:0] p0_q, p1_q;
  logic [13:0] lowHalf_q;
  logic        halfPending_q;
  logic [scwp_pkg::PIPE_DEPTH-1:0] fselPipe_q, pselPipe_q;
  logic [scwp_pkg::PIPE_DEPTH-1:0] loadPipe_q;
  logic [27:0] incr_q;
  logic [11:0] offs_q;
  logic        rstCore_q, sleep_q, sq_q, strobe_q;
  logic [1:0]  rstSync_q, slpSync_q, fpSync_q, ppSync_q;

  // pin inputs except selLate and loadLate pass two flip-flops before use
  always_ff @(posedge clk_sys) begin
    clkSync_q <= {clkSync_q[0], link.serialClk};
    fsSync_q  <= {fsSync_q[0], link.frameSyncN};
    datSync_q <= {datSync_q[0], link.serialData};
    rstSync_q <= {rstSync_q[0], resetPin};
    slpSync_q <= {slpSync_q[0], sleepPin};
    fpSync_q  <= {fpSync_q[0], freq_select_pin};
    ppSync_q  <= {ppSync_q[0], phase_select_pin};
  end

  // edge and frame decode
  wire frameActive = ~fsSync_q[1];
  wire fallEdge    = clkPrev_q & ~clkSync_q[1];
  // RL2: level sensitive enable
  wire takeBit     = frameActive & fallEdge;
  wire [15:0] nextShift = {shift_q[14:0], datSync_q[1]};
  // RL1: sixteen bits make a word
  wire wordDone    = takeBit & (count_q == 5'(scwp_pkg::WORD_BITS - 1));
  // RL17: destination decode
  wire [1:0] dest  = nextShift[15:14];
  wire fullMode    = ctrl_q[scwp_pkg::BIT_FULL_WORD];
  wire hiSel       = ctrl_q[scwp_pkg::BIT_HALF_SEL];

  // RL3: shift on falling serial edge
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      clkPrev_q <= 1'b1;
      shift_q   <= 16'h0000;
      count_q   <= 5'h00;
    end else begin
      clkPrev_q <= clkSync_q[1];
      // RL18: short frame drops partial word
      if (!frameActive) begin
        count_q <= 5'h00;
      end else if (takeBit) begin
        shift_q <= nextShift;
        // RL5: counter wraps for back-to-back words
        count_q <= wordDone ? 5'h00 : count_q + 5'h01;
      end
    end
  end

  // merge of a 14-bit half into a frequency register
  function automatic logic [27:0] mergeHalf(input logic [27:0] old,
                                            input logic [13:0] half,
                                            input logic        high);
    mergeHalf = high ? {half, old[13:0]} : {old[27:14], half};
  endfunction

  wire isFreq    = (dest == scwp_pkg::DEST_FREQ_REG_ZERO) |
                   (dest == scwp_pkg::DEST_FREQ_REG_ONE);
  // RL15: second write completes full word
  wire fullFinal = fullMode & halfPending_q;
  wire [27:0] oldF = (dest == scwp_pkg::DEST_FREQ_REG_ZERO) ? f0_q : f1_q;
  wire [27:0] newF = fullMode ? {nextShift[13:0], lowHalf_q}
                              : mergeHalf(oldF, nextShift[13:0], hiSel);
  wire freqWrite = wordDone & isFreq & (~fullMode | fullFinal);

  // register file update, one write per word
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_q        <= scwp_pkg::CTRL_RESET_VALUE;
      f0_q          <= 28'h0000000;
      f1_q          <= 28'h0000000;
      p0_q          <= 12'h000;
      p1_q          <= 12'h000;
      lowHalf_q     <= 14'h0000;
      halfPending_q <= 1'b0;
      strobe_q      <= 1'b0;
    end else begin
      strobe_q <= wordDone;
      if (wordDone) begin
        // RL12: top bits zero hit control
        if (dest == scwp_pkg::DEST_CTRL) begin
          ctrl_q        <= nextShift;
          halfPending_q <= 1'b0;
        end else if (isFreq && fullMode && !halfPending_q) begin
          lowHalf_q     <= nextShift[13:0];
          halfPending_q <= 1'b1;
        end else if (isFreq) begin
          halfPending_q <= 1'b0;
        end else if (nextShift[scwp_pkg::BIT_PHASE_REG]) begin
          p1_q <= nextShift[11:0];
        end else begin
          p0_q <= nextShift[11:0];
        end
        if (freqWrite && dest == scwp_pkg::DEST_FREQ_REG_ZERO) begin
          f0_q <= newF;
        end
        if (freqWrite && dest == scwp_pkg::DEST_FREQ_REG_ONE) begin
          f1_q <= newF;
        end
      end
    end
  end

  // RL16: pin or software source
  wire pinMode  = ctrlCore_q[scwp_pkg::BIT_PIN_SOFT];
  wire fselSrc  = pinMode ? fpSync_q[1]
                          : ctrlCore_q[scwp_pkg::BIT_FREQ_SEL];
  wire pselSrc  = pinMode ? ppSync_q[1]
                          : ctrlCore_q[scwp_pkg::BIT_PHASE_SEL];
  wire rstSrc   = pinMode ? rstSync_q[1]
                          : ctrlCore_q[scwp_pkg::BIT_RESET];
  wire slpSrc   = pinMode ? slpSync_q[1]
                          : ctrlCore_q[scwp_pkg::BIT_SLEEP_DAC];
  // RL7: base select latency
  // RL8: late pin adds a cycle
  // two sync flops, the half cycle into the core and the output
  // register use up part of the budget, so the taps are shorter
  wire [3:0] selTap  = 4'(SEL_DELAY - 4) + {3'h0, selLate};
  // RL9: load latency eight or nine
  wire [3:0] loadTap = 4'(LOAD_DELAY - 3) + {3'h0, loadLate};
  wire selMoved = fselPipe_q[selTap] != fselPipe_q[selTap + 4'h1];
  // RL14: increment source choice
  wire [27:0] incrSel = fselPipe_q[selTap] ? f1_q : f0_q;
  wire [11:0] offsSel = pselPipe_q[selTap] ? p1_q : p0_q;

  // core side runs on the falling edge, as the inner core does
  // RL11: control sampled on falling edge
  // RL10: reset and sleep sampled on falling edge
  always_ff @(negedge clk_sys) begin
    if (sys_rst) begin
      ctrlCore_q <= scwp_pkg::CTRL_RESET_VALUE;
      fselPipe_q <= '0;
      pselPipe_q <= '0;
      loadPipe_q <= '0;
      incr_q     <= 28'h0000000;
      offs_q     <= 12'h000;
      rstCore_q  <= 1'b0;
      sleep_q    <= 1'b0;
      sq_q       <= 1'b0;
    end else begin
      ctrlCore_q <= ctrl_q;
      fselPipe_q <= {fselPipe_q[scwp_pkg::PIPE_DEPTH-2:0], fselSrc};
      pselPipe_q <= {pselPipe_q[scwp_pkg::PIPE_DEPTH-2:0], pselSrc};
      loadPipe_q <= {loadPipe_q[scwp_pkg::PIPE_DEPTH-2:0], strobe_q};
      // phaseIncrement refreshes only when a select or load has matured; phaseOffset every cycle
      if (loadPipe_q[loadTap] || selMoved) begin
        incr_q <= incrSel;
      end
      offs_q    <= offsSel;
      rstCore_q <= rstSrc;
      sleep_q   <= slpSrc;
      // RL13: comparator needs both bits
      sq_q <= ctrlCore_q[scwp_pkg::BIT_SIGN_SEL] &
              ctrlCore_q[scwp_pkg::BIT_DIG_OUT];
    end
  end

  assign controlWord     = ctrl_q;
  assign freq_reg_zero   = f0_q;
  assign freq_reg_one    = f1_q;
  assign phaseReg0       = p0_q;
  assign phaseReg1       = p1_q;
  assign phaseIncrement  = incr_q;
  assign phaseOffset     = offs_q;
  assign coreReset       = rstCore_q;
  assign dacSleep        = sleep_q;
  assign squareOutEnable = sq_q;
  assign wordStrobe      = strobe_q;
endmodule

// ---- scwp_host.sv ----
// host end: sends 16-bit words, serial clock made by divider
`timescale 1ns/1ps
module scwp_host (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // serial link
  scwp_if.host             link,
  // user request
  input  wire logic        sendValid,
  input  wire logic [15:0] sendWord,
  input  wire logic        sendLast,
  output logic             sendReady,
  output logic             busy
);
  scwp_pkg::scwp_host_state_t state_q, state_d;
  logic [scwp_pkg::HOST_DIV_BITS-1:0] div_q;
  logic [3:0]  bit_q;
  logic [15:0] word_q;
  logic        last_q, sclk_q, fsN_q, ready_q, busy_q;

  // divider end marks each serial half period
  wire halfDone = (div_q == scwp_pkg::HOST_DIV_BITS'(
                   scwp_pkg::HOST_HALF_PERIOD - 1));
  wire inIdle   = (state_q == scwp_pkg::HST_IDLE);
  wire inShift  = (state_q == scwp_pkg::HST_SHIFT);
  wire inEnd    = (state_q == scwp_pkg::HST_END);
  // a word is taken from idle, or mid-frame when more words follow
  wire accept   = sendValid & (inIdle | (inEnd & ~last_q));
  // RL4: frame ends only after sixteenth fall
  wire lastRise = inShift & halfDone & ~sclk_q & (bit_q == 4'hF);

  // next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      scwp_pkg::HST_IDLE: begin
        if (accept) state_d = scwp_pkg::HST_SHIFT;
      end
      scwp_pkg::HST_SHIFT: begin
        if (lastRise) state_d = scwp_pkg::HST_END;
      end
      scwp_pkg::HST_END: begin
        if (accept) state_d = scwp_pkg::HST_SHIFT;
        else if (last_q && halfDone) state_d = scwp_pkg::HST_IDLE;
      end
      default: state_d = scwp_pkg::HST_IDLE;
    endcase
  end

  // divider, shifter and frame control
  // RL6: clock parked high whenever frame sync falls
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q <= scwp_pkg::HST_IDLE;
      div_q   <= '0;
      bit_q   <= 4'h0;
      word_q  <= 16'h0000;
      last_q  <= 1'b1;
      sclk_q  <= 1'b1;
      fsN_q   <= 1'b1;
      ready_q <= 1'b0;
      busy_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      ready_q <= accept;
      busy_q  <= (state_d != scwp_pkg::HST_IDLE);
      div_q   <= (halfDone | accept) ? '0 : div_q + 1'b1;
      if (accept) begin
        word_q <= sendWord;
        last_q <= sendLast;
        bit_q  <= 4'h0;
        fsN_q  <= 1'b0;
      end else if (inShift && halfDone) begin
        sclk_q <= ~sclk_q;
        // data moves only on rising edges, so it stands while low
        if (!sclk_q) begin
          word_q <= {word_q[14:0], 1'b0};
          bit_q  <= bit_q + 4'h1;
        end
      end else if (inEnd && last_q) begin
        // RL5: frame released after the last word
        fsN_q <= 1'b1;
      end
    end
  end

  // RL1: one 16-bit word, msb first
  assign link.serialClk  = sclk_q;
  assign link.frameSyncN = fsN_q;
  assign link.serialData = word_q[15];
  assign sendReady       = ready_q;
  assign busy            = busy_q;
endmodule

// ---- scwp_if.sv ----
// interface joining host and device serial ends
`timescale 1ns/1ps
interface scwp_if;
  logic serialClk;
  logic frameSyncN;
  logic serialData;
  modport host (output serialClk, output frameSyncN, output serialData);
  modport device (input serialClk, input frameSyncN, input serialData);
endinterface

// ---- scwp_pkg.sv ----
// package of constants and types for the serial control word port
// Functional notes
// RL1: every transfer is one 16-bit word
// RL2: data accepted only while frame sync low
// RL3: shift one bit per falling serial edge
// RL4: host raises frame sync after sixteenth edge
// RL5: back-to-back words under one low frame
// RL6: serial clock high when frame sync falls
// RL7: select pin change acts after eight cycles
// RL8: late select change adds one cycle
// RL9: register load reaches output eight or nine
// RL10: reset and sleep falls sampled on falling
// RL11: control bits sampled on falling core edge
// RL12: top bits zero update control register
// RL13: comparator needs sign select and digital enable
// RL14: increment from frequency register zero or one
// RL15: full-word mode pairs low then high halves
// RL16: one bit picks pin or software control
// RL17: decode top bits, single register update
// RL18: short frame discards partial word
package scwp_pkg;
  localparam int WORD_BITS  = 16;
  localparam int HALF_BITS  = 14;
  localparam int FREQ_BITS  = 28;
  localparam int PHASE_BITS = 12;
  localparam int CNT_BITS   = 5;
  // destination codes in the top two bits
  localparam logic [1:0] DEST_CTRL  = 2'h0;
  localparam logic [1:0] DEST_FREQ_REG_ZERO = 2'h1;
  localparam logic [1:0] DEST_FREQ_REG_ONE = 2'h2;
  localparam logic [1:0] DEST_PHASE = 2'h3;
  // control word and phase word field positions
  localparam int BIT_FULL_WORD = 13;
  localparam int BIT_HALF_SEL  = 12;
  localparam int BIT_FREQ_SEL  = 11;
  localparam int BIT_PHASE_SEL = 10;
  localparam int BIT_PIN_SOFT  = 9;
  localparam int BIT_RESET     = 8;
  localparam int BIT_SLEEP_DAC = 6;
  localparam int BIT_DIG_OUT   = 5;
  localparam int BIT_SIGN_SEL  = 4;
  localparam int BIT_PHASE_REG = 13;
  localparam logic [15:0] CTRL_RESET_VALUE = 16'h0000;
  // latencies in core cycles
  localparam int SEL_LATENCY   = 8;
  localparam int LOAD_LATENCY  = 8;
  localparam int PIPE_DEPTH    = 10;
  // host serial clock divider: half period in core cycles
  localparam int HOST_HALF_PERIOD = 4;
  localparam int HOST_DIV_BITS    = 3;
  typedef enum logic [2:0] {
    HST_IDLE  = 3'b001,
    HST_SHIFT = 3'b010,
    HST_END   = 3'b100
  } scwp_host_state_t;
endpackage

// ---- scwp_sva.sv ----
// wire checks on the serial link between the host and device ends
`timescale 1ns/1ps
module scwp_sva (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic sys_rst,
  // serial link
  input  wire logic serialClk,
  input  wire logic frameSyncN,
  input  wire logic serialData
);
  logic [7:0] fallCnt_q;
  logic       clkPrev_q;
  wire        clkFall = clkPrev_q & ~serialClk;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // falls counted per frame; cleared while the frame is idle
  always_ff @(posedge clk_sys) begin
    clkPrev_q <= sys_rst ? 1'b1 : serialClk;
    fallCnt_q <= (sys_rst | frameSyncN) ? 8'h00 : fallCnt_q + {7'h00, clkFall};
  end
  // divider holds each low half for several core cycles
  sequence lowHold;
    !serialClk [*3];
  endsequence
  // clock stays parked high a while after the frame opens
  sequence highHold;
    serialClk [*3];
  endsequence
  chk_clk_high_fall: assert property ($fell(frameSyncN) |-> serialClk)
    else $error("frame opened with serial clock low");
  chk_open_setup: assert property ($fell(frameSyncN) |-> highHold)
    else $error("serial clock fell too soon after frame opened");
  chk_idle_clk_high: assert property (frameSyncN |-> serialClk)
    else $error("serial clock low outside a frame");
  chk_frame_whole: assert property ($rose(frameSyncN) |->
    (fallCnt_q != 8'h00) && (fallCnt_q[3:0] == 4'h0))
    else $error("frame closed off a word boundary");
  chk_clk_half_period: assert property ($fell(serialClk) |-> lowHold)
    else $error("serial clock low half too short");
  chk_data_settled: assert property (!frameSyncN && !serialClk &&
    $past(!serialClk) |-> $stable(serialData))
    else $error("data moved while clock low");
  cover property ($rose(frameSyncN) && fallCnt_q == 8'h20);
endmodule
